// [include/slg_pkg.sv]
// ============================================================
// Overview of operation
// - every word read from ram, rom or nvm is checked against its stored error detection code and a mismatch is flagged as an integrity error.
// - a single-bit error in an nvm word is corrected in hardware and the corrected value is delivered.
// - an error of more than one bit is never corrected silently and raises an observable indication.
// - every loader request is refused until the host has completed mutual authentication.
// - the loader can be locked permanently and no later command clears the lock.
// - once locked, every loader access is denied even to an authenticated host.
// - an image is programmed only when its signature verified correctly, otherwise programming is rejected.
// - during authentication the device proves its own identity through the mutual authentication unit.
// - on parts without an activatable loader the loader and its authentication are deactivated and all requests are refused.
// - a loader request after deactivation never reads out or modifies stored user data.
`default_nettype none
package slg_pkg;
    // ============================================================
    // data word, address and code widths
    localparam int DATA_W = 32;
    localparam int CODE_W = 7;
    localparam int ADDR_W = 16;
    localparam int SYND_W = 6;
    // memory sources
    localparam logic [1:0] SRC_RAM = 2'h0;
    localparam logic [1:0] SRC_ROM = 2'h1;
    localparam logic [1:0] SRC_NVM = 2'h2;
    // loader commands
    localparam logic [1:0] CMD_READ = 2'h0;
    localparam logic [1:0] CMD_PROG = 2'h1;
    localparam logic [1:0] CMD_LOCK = 2'h2;
    // loader answer status
    localparam logic [2:0] ST_OK = 3'h0;
    localparam logic [2:0] ST_NOAUTH = 3'h1;
    localparam logic [2:0] ST_LOCKED = 3'h2;
    localparam logic [2:0] ST_BADSIG = 3'h3;
    localparam logic [2:0] ST_DISABLED = 3'h4;
    localparam logic [2:0] ST_BADCMD = 3'h5;
    // ============================================================
    // host loader request
    typedef struct packed {
        logic [1:0] cmd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] data;
        logic sig_ok;
    } slg_req_t;
    // loader answer
    typedef struct packed {
        logic [2:0] status;
        logic [DATA_W-1:0] data;
    } slg_rsp_t;
    // memory word with its code
    typedef struct packed {
        logic [1:0] src;
        logic [DATA_W-1:0] data;
        logic [CODE_W-1:0] code;
    } slg_word_t;
    // checked word result
    typedef struct packed {
        logic [DATA_W-1:0] data;
        logic err;
        logic corrected;
        logic multi;
    } slg_chk_t;
endpackage
`default_nettype wire

// [rtl/slg_gate.sv]
`default_nettype none
module slg_gate (
    input wire logic core_clk,
    input wire logic reset,
    // part straps and non-volatile lock
    input wire logic loader_fitted,
    input wire logic nvm_lock_bit,
    output logic nvm_lock_write,
    // mutual authentication unit
    input wire logic auth_pass,
    input wire logic auth_fail,
    input wire logic auth_proof_valid,
    output logic auth_enable,
    output logic auth_prove,
    // host loader request and answer
    input wire logic req_valid,
    input wire slg_pkg::slg_req_t req,
    output logic rsp_valid,
    output slg_pkg::slg_rsp_t rsp,
    // memory port toward the nvm
    output logic mem_rd,
    output logic mem_wr,
    output logic [slg_pkg::ADDR_W-1:0] mem_addr,
    output logic [slg_pkg::DATA_W-1:0] mem_wdata,
    // integrity checking of stored words
    input wire logic word_valid,
    input wire slg_pkg::slg_word_t word,
    output logic chk_valid,
    output slg_pkg::slg_chk_t chk,
    output logic integrity_err,
    output logic multi_bit_err
);
    // ============================================================
    // access state
    typedef enum logic [1:0] {
        SLG_IDLE = 2'b00,
        SLG_AUTHED = 2'b01,
        SLG_LOCKED = 2'b10,
        SLG_OFF = 2'b11
    } slg_state_t;
    slg_state_t state;
    slg_state_t next_state;
    logic sampled;
    // ============================================================
    // state walk; the lock is sampled on the first cycle after reset
    always_comb begin
        next_state = state;
        unique case (state)
            SLG_IDLE: begin
                if (auth_pass && auth_proof_valid) begin
                    next_state = SLG_AUTHED;
                end
            end
            SLG_AUTHED: begin
                if (auth_fail) begin
                    next_state = SLG_IDLE;
                end
            end
            SLG_LOCKED: next_state = SLG_LOCKED;
            SLG_OFF: next_state = SLG_OFF;
        endcase
        if (!sampled) begin
            if (!loader_fitted) begin
                next_state = SLG_OFF;
            end else if (nvm_lock_bit) begin
                next_state = SLG_LOCKED;
            end else begin
                next_state = SLG_IDLE;
            end
        end else if (state == SLG_AUTHED && req_valid && req.cmd == slg_pkg::CMD_LOCK) begin
            next_state = SLG_LOCKED;
        end
    end
    always_ff @(posedge core_clk) begin
        if (reset) begin
            state <= SLG_OFF;
            sampled <= 1'b0;
        end else begin
            state <= next_state;
            sampled <= 1'b1;
        end
    end
    // authentication unit only runs while the loader can still be used
    always_ff @(posedge core_clk) begin
        if (reset) begin
            auth_enable <= 1'b0;
            auth_prove <= 1'b0;
        end else begin
            auth_enable <= sampled && next_state == SLG_IDLE;
            auth_prove <= sampled && next_state == SLG_IDLE;
        end
    end
    // ============================================================
    // loader request decode
    logic grant;
    logic [2:0] next_status;
    always_comb begin
        grant = 1'b0;
        next_status = slg_pkg::ST_OK;
        if (!sampled || state == SLG_OFF) begin
            next_status = slg_pkg::ST_DISABLED;
        end else if (state == SLG_LOCKED) begin
            next_status = slg_pkg::ST_LOCKED;
        end else if (state != SLG_AUTHED) begin
            next_status = slg_pkg::ST_NOAUTH;
        end else if (req.cmd == slg_pkg::CMD_PROG && !req.sig_ok) begin
            next_status = slg_pkg::ST_BADSIG;
        end else if (req.cmd == 2'h3) begin
            next_status = slg_pkg::ST_BADCMD;
        end else begin
            grant = 1'b1;
        end
    end
    // memory strobes only on granted requests
    always_ff @(posedge core_clk) begin
        if (reset) begin
            mem_rd <= 1'b0;
            mem_wr <= 1'b0;
            mem_addr <= '0;
            mem_wdata <= '0;
            nvm_lock_write <= 1'b0;
        end else begin
            mem_rd <= req_valid && grant && req.cmd == slg_pkg::CMD_READ;
            mem_wr <= req_valid && grant && req.cmd == slg_pkg::CMD_PROG;
            nvm_lock_write <= req_valid && grant && req.cmd == slg_pkg::CMD_LOCK;
            if (req_valid && grant) begin
                mem_addr <= req.addr;
                mem_wdata <= req.data;
            end
        end
    end
    // one answer per request, one cycle after it
    always_ff @(posedge core_clk) begin
        if (reset) begin
            rsp_valid <= 1'b0;
            rsp <= '0;
        end else begin
            rsp_valid <= req_valid;
            if (req_valid) begin
                rsp.status <= next_status;
                rsp.data <= '0;
            end
        end
    end
    // ============================================================
    // hamming secded check: code[5:0] are position parities, code[6] overall
    localparam int SYND_W_L = slg_pkg::SYND_W;
    logic [SYND_W_L-1:0] synd;
    logic synd_hit;
    logic [slg_pkg::DATA_W-1:0] fixed;
    logic overall;
    logic [5:0] pos [slg_pkg::DATA_W];
    genvar gi;
    generate
        for (gi = 0; gi < slg_pkg::DATA_W; gi++) begin : g_pos
            // data bit gi sits at a non power of two hamming position
            assign pos[gi] = 6'(gi + 3 + ((gi >= 1) ? 1 : 0) + ((gi >= 4) ? 1 : 0) + ((gi >= 11) ? 1 : 0)
                + ((gi >= 26) ? 1 : 0));
        end
    endgenerate
    always_comb begin
        synd = word.code[5:0];
        overall = ^{word.data, word.code};
        for (int i = 0; i < slg_pkg::DATA_W; i++) begin
            if (word.data[i]) begin
                synd = synd ^ pos[i];
            end
        end
        // a syndrome that names no bit position can only come from several flips
        synd_hit = (synd & (synd - 6'h1)) == '0;
        for (int i = 0; i < slg_pkg::DATA_W; i++) begin
            if (synd == pos[i]) begin
                synd_hit = 1'b1;
            end
        end
        fixed = word.data;
        for (int i = 0; i < slg_pkg::DATA_W; i++) begin
            if (synd == pos[i] && overall && word.src == slg_pkg::SRC_NVM) begin
                fixed[i] = ~word.data[i];
            end
        end
    end
    logic single;
    logic multi;
    // odd parity with a known position is one flip, any other non-zero syndrome is several
    assign single = overall && synd_hit;
    assign multi = synd != '0 && !single;
    // checked word output and sticky-free event flags
    always_ff @(posedge core_clk) begin
        if (reset) begin
            chk_valid <= 1'b0;
            chk <= '0;
            integrity_err <= 1'b0;
            multi_bit_err <= 1'b0;
        end else begin
            chk_valid <= word_valid;
            integrity_err <= word_valid && (single || multi);
            multi_bit_err <= word_valid && (multi || (single && word.src != slg_pkg::SRC_NVM));
            if (word_valid) begin
                chk.data <= fixed;
                chk.err <= single || multi;
                chk.corrected <= single && word.src == slg_pkg::SRC_NVM;
                chk.multi <= multi;
            end
        end
    end
    // ============================================================
    // checks
    a_lock_sticky: assert property (@(posedge core_clk) disable iff (reset)
        state == SLG_LOCKED |=> state == SLG_LOCKED) else $error("lock was cleared");
    a_locked_deny: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && state == SLG_LOCKED && sampled |=> rsp.status == slg_pkg::ST_LOCKED && !mem_wr && !mem_rd)
        else $error("locked loader granted access");
    a_noauth_deny: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && state == SLG_IDLE && sampled |=> rsp.status == slg_pkg::ST_NOAUTH && !mem_wr)
        else $error("unauthenticated request granted");
    a_badsig_reject: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && req.cmd == slg_pkg::CMD_PROG && !req.sig_ok |=> !mem_wr)
        else $error("unsigned image programmed");
    a_off_dead: assert property (@(posedge core_clk) disable iff (reset)
        state == SLG_OFF && sampled |=> state == SLG_OFF && !auth_enable) else $error("disabled loader revived");
    a_off_nomem: assert property (@(posedge core_clk) disable iff (reset)
        $past(state) == SLG_OFF |-> !mem_rd && !mem_wr) else $error("disabled loader touched memory");
    a_err_flag: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && (single || multi) |=> integrity_err && chk.err) else $error("integrity error missed");
    a_multi_flag: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && multi |=> multi_bit_err && !chk.corrected) else $error("multi bit error hidden");
    a_nvm_fix: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && single && word.src == slg_pkg::SRC_NVM |=> chk.corrected && !multi_bit_err)
        else $error("nvm single error not corrected");
    a_lock_sample: assert property (@(posedge core_clk)
        $rose(sampled) && $past(nvm_lock_bit) && $past(loader_fitted) |-> state == SLG_LOCKED)
        else $error("stored lock not honoured");
    // a locked part read back from the lock cell goes straight to locked
    a_lock_first: assert property (@(posedge core_clk) disable iff (reset)
        !sampled && loader_fitted && nvm_lock_bit |=> state == SLG_LOCKED)
        else $error("stored lock missed at start");
    // a part without loader stays dead from the first cycle on
    a_off_first: assert property (@(posedge core_clk) disable iff (reset)
        !sampled && !loader_fitted |=> state == SLG_OFF && !auth_enable)
        else $error("loader alive on part without loader");
    // requests before the straps are read never reach memory
    a_unsampled_deny: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && !sampled |=> rsp.status == slg_pkg::ST_DISABLED && !mem_rd && !mem_wr)
        else $error("request served before straps were read");
    // ============================================================
    // access control checks
    // a proof that the host does not accept leaves the loader closed
    a_auth_proof: assert property (@(posedge core_clk) disable iff (reset)
        sampled && state == SLG_IDLE && auth_pass && !auth_proof_valid |=> state == SLG_IDLE)
        else $error("loader opened without device proof");
    // the authenticated state is only reached through a passed exchange
    a_auth_gate: assert property (@(posedge core_clk) disable iff (reset)
        sampled && state != SLG_AUTHED && !(state == SLG_IDLE && auth_pass && auth_proof_valid)
        |=> state != SLG_AUTHED)
        else $error("loader opened without authentication");
    // every memory or lock strobe comes from a request taken while authenticated
    a_strobe_authed: assert property (@(posedge core_clk) disable iff (reset)
        mem_rd || mem_wr || nvm_lock_write |-> $past(state) == SLG_AUTHED)
        else $error("memory strobe outside authenticated state");
    // the lock cell is written only together with the move into locked
    a_lock_cell: assert property (@(posedge core_clk) disable iff (reset)
        nvm_lock_write |-> state == SLG_LOCKED)
        else $error("lock written without locking");
    // the device offers its proof only while the loader waits for a host
    a_prove_idle: assert property (@(posedge core_clk) disable iff (reset)
        auth_prove |-> state == SLG_IDLE && auth_enable)
        else $error("device proof offered outside idle");
    // a locked loader keeps the authentication unit asleep
    a_locked_quiet: assert property (@(posedge core_clk) disable iff (reset)
        state == SLG_LOCKED |-> !auth_enable && !auth_prove)
        else $error("locked loader still authenticating");
    // a dead loader answers disabled and never writes the lock cell
    a_off_status: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && sampled && state == SLG_OFF |=> rsp.status == slg_pkg::ST_DISABLED && !nvm_lock_write)
        else $error("disabled loader answered");
    // a program request with a failed signature is reported as such
    a_badsig_status: assert property (@(posedge core_clk) disable iff (reset)
        req_valid && sampled && state == SLG_AUTHED && req.cmd == slg_pkg::CMD_PROG && !req.sig_ok
        |=> rsp.status == slg_pkg::ST_BADSIG)
        else $error("unsigned image not reported");
    // every request is answered on the next cycle
    a_rsp_follows: assert property (@(posedge core_clk) disable iff (reset)
        req_valid |=> rsp_valid)
        else $error("request left unanswered");
    // ============================================================
    // integrity checks
    // a clean word passes unchanged and raises nothing
    a_clean_pass: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && synd == '0 && !overall |=> !integrity_err && !chk.err && chk.data == $past(word.data))
        else $error("clean word flagged or altered");
    // ram and rom words are never rewritten by the corrector
    a_ram_untouched: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && word.src != slg_pkg::SRC_NVM |=> !chk.corrected && chk.data == $past(word.data))
        else $error("ram or rom word rewritten");
    // several flipped bits are passed on as read, never patched
    a_multi_keep: assert property (@(posedge core_clk) disable iff (reset)
        word_valid && multi |=> chk.data == $past(word.data) && chk.err)
        else $error("multi bit error silently patched");
    // ============================================================
    // scenario covers
    c_auth: cover property (@(posedge core_clk) state == SLG_IDLE ##1 state == SLG_AUTHED);
    c_prog: cover property (@(posedge core_clk) mem_wr);
    c_lock: cover property (@(posedge core_clk) state == SLG_AUTHED ##1 state == SLG_LOCKED);
    c_fix: cover property (@(posedge core_clk) chk_valid && chk.corrected);
    c_multi: cover property (@(posedge core_clk) chk_valid && chk.multi);
endmodule
`default_nettype wire

// [tb/slg_host_model.sv]
`default_nettype none
// ============================================================
// programming host side: auth answers and the nvm lock cell
module slg_host_model #(
    parameter int LAT = 2
) (
    input wire logic core_clk,
    input wire logic want_auth,
    input wire logic want_fail,
    input wire logic proof_ok,
    input wire logic auth_enable,
    input wire logic auth_prove,
    input wire logic nvm_lock_write,
    output logic auth_pass,
    output logic auth_fail,
    output logic auth_proof_valid,
    output logic nvm_lock_bit
);
    timeunit 1ns;
    timeprecision 1ps;
    int wait_cnt = 0;
    initial begin
        auth_pass = 1'b0;
        auth_fail = 1'b0;
        nvm_lock_bit = 1'b0;
    end
    // lock cell has no reset: once set it survives every reset
    always @(posedge core_clk) begin
        if (nvm_lock_write) nvm_lock_bit <= 1'b1;
    end
    // the device proof is only accepted while the device offers it
    assign auth_proof_valid = auth_prove & proof_ok;
    // host answers the challenge after LAT+1 cycles with a pass pulse
    always @(posedge core_clk) begin
        auth_pass <= 1'b0;
        auth_fail <= want_fail;
        if (want_auth && auth_enable) begin
            wait_cnt <= wait_cnt + 1;
            if (wait_cnt == LAT) begin
                auth_pass <= 1'b1;
                wait_cnt <= 0;
            end
        end else begin
            wait_cnt <= 0;
        end
    end
endmodule
`default_nettype wire

// [tb/tb_secure_loader_gate_with_nvm_ecc.sv]
`default_nettype none
module tb_secure_loader_gate_with_nvm_ecc;
    timeunit 1ns;
    timeprecision 1ps;
    logic core_clk = 0, reset = 1, loader_fitted = 0, req_valid = 0, word_valid = 0;
    logic want_auth = 0, want_fail = 0, proof_ok = 1;
    logic nvm_lock_bit, nvm_lock_write, auth_pass, auth_fail, auth_proof_valid, auth_enable, auth_prove;
    logic rsp_valid, mem_rd, mem_wr, chk_valid, integrity_err, multi_bit_err;
    logic [slg_pkg::ADDR_W-1:0] mem_addr;
    logic [slg_pkg::DATA_W-1:0] mem_wdata;
    slg_pkg::slg_req_t req = '0;
    slg_pkg::slg_rsp_t rsp;
    slg_pkg::slg_word_t word = '0;
    slg_pkg::slg_chk_t chk;
    int err_total = 0, check_count = 0;
    always #2 core_clk = ~core_clk;
    slg_gate dut (.core_clk, .reset, .loader_fitted, .nvm_lock_bit, .nvm_lock_write, .auth_pass, .auth_fail,
        .auth_proof_valid, .auth_enable, .auth_prove, .req_valid, .req, .rsp_valid, .rsp, .mem_rd, .mem_wr,
        .mem_addr, .mem_wdata, .word_valid, .word, .chk_valid, .chk, .integrity_err, .multi_bit_err);
    slg_host_model #(.LAT(2)) host (.core_clk, .want_auth, .want_fail, .proof_ok, .auth_enable, .auth_prove,
        .nvm_lock_write, .auth_pass, .auth_fail, .auth_proof_valid, .nvm_lock_bit);
    // ============================================================
    // shared helpers
    task automatic check(input logic [63:0] got, input logic [63:0] exp);
        check_count++;
        if (got !== exp) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wrap_up();
        if (err_total == 0 && check_count > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask
    task automatic do_reset();
        reset = 1;
        repeat (4) @(posedge core_clk);
        #1 reset = 0;
        repeat (2) @(posedge core_clk);
        #1;
    endtask
    // one request, answer judged one cycle later; valid stays up for back to back use
    task automatic send(input logic [1:0] cmd, input logic sig, input logic [2:0] st, input logic rd,
        input logic wr, input logic lk);
        req = '{cmd: cmd, addr: 16'h00a5, data: 32'h1234_5678, sig_ok: sig};
        req_valid = 1;
        @(posedge core_clk);
        #1;
        check(64'({rsp_valid, rsp.status, mem_rd, mem_wr, nvm_lock_write, rsp.data}),
            64'({1'b1, st, rd, wr, lk, 32'h0000_0000}));
        if (rd || wr) check(64'(mem_addr), 64'(16'h00a5));
        if (wr) check(64'(mem_wdata), 64'(32'h1234_5678));
    endtask
    task automatic rel();
        req_valid = 0;
        @(posedge core_clk);
        #1;
    endtask
    task automatic authenticate(input logic ok);
        check(64'(auth_prove), 64'(1));
        proof_ok = ok;
        want_auth = 1;
        for (int n = 0; n < 10 && auth_enable === 1'b1; n++) begin
            @(posedge core_clk);
            #1;
        end
        want_auth = 0;
        check(64'({auth_enable, auth_prove}), 64'({!ok, !ok}));
        if (ok && auth_enable !== 1'b0) wrap_up();
    endtask
    function automatic logic [6:0] enc(input logic [31:0] d);
        logic [5:0] s;
        int p;
        s = '0;
        p = 3;
        for (int i = 0; i < 32; i++) begin
            while ((p & (p - 1)) == 0) p++;
            if (d[i]) s ^= p[5:0];
            p++;
        end
        return {^{d, s}, s};
    endfunction
    // exp holds err, corrected, multi; mbe is the expected multi_bit_err pulse
    task automatic ecc(input logic [1:0] src, input logic [38:0] flip, input logic [2:0] exp, input logic mbe);
        logic [31:0] d;
        d = 32'hc0de_5a17;
        word = {src, {d, enc(d)} ^ flip};
        word_valid = 1;
        @(posedge core_clk);
        #1 word_valid = 0;
        check(64'({chk_valid, chk.err, chk.corrected, chk.multi, integrity_err, multi_bit_err}),
            64'({1'b1, exp, exp[2], mbe}));
        if (!mbe) check(64'(chk.data), 64'(d));
        else check(64'(chk.data), 64'(d ^ flip[38:7]));
        @(posedge core_clk);
        #1;
    endtask
    // ============================================================
    // main sequence
    initial begin
        do_reset();
        check(64'({auth_enable, auth_prove}), 64'(0));
        send(slg_pkg::CMD_PROG, 1, slg_pkg::ST_DISABLED, 0, 0, 0);
        send(slg_pkg::CMD_READ, 1, slg_pkg::ST_DISABLED, 0, 0, 0);
        rel();
        loader_fitted = 1;
        do_reset();
        send(slg_pkg::CMD_READ, 1, slg_pkg::ST_NOAUTH, 0, 0, 0);
        send(slg_pkg::CMD_LOCK, 1, slg_pkg::ST_NOAUTH, 0, 0, 0);
        rel();
        authenticate(0);
        send(slg_pkg::CMD_PROG, 1, slg_pkg::ST_NOAUTH, 0, 0, 0);
        rel();
        authenticate(1);
        send(slg_pkg::CMD_PROG, 1, slg_pkg::ST_OK, 0, 1, 0);
        send(slg_pkg::CMD_PROG, 0, slg_pkg::ST_BADSIG, 0, 0, 0);
        send(slg_pkg::CMD_READ, 1, slg_pkg::ST_OK, 1, 0, 0);
        send(2'h3, 1, slg_pkg::ST_BADCMD, 0, 0, 0);
        rel();
        want_fail = 1;
        rel();
        want_fail = 0;
        repeat (3) rel();
        send(slg_pkg::CMD_READ, 1, slg_pkg::ST_NOAUTH, 0, 0, 0);
        rel();
        authenticate(1);
        send(slg_pkg::CMD_LOCK, 1, slg_pkg::ST_OK, 0, 0, 1);
        send(slg_pkg::CMD_PROG, 1, slg_pkg::ST_LOCKED, 0, 0, 0);
        rel();
        do_reset();
        check(64'({auth_enable, auth_prove}), 64'(0));
        send(slg_pkg::CMD_PROG, 1, slg_pkg::ST_LOCKED, 0, 0, 0);
        send(slg_pkg::CMD_LOCK, 1, slg_pkg::ST_LOCKED, 0, 0, 0);
        rel();
        ecc(slg_pkg::SRC_NVM, 39'h0, 3'h0, 1'b0);
        ecc(slg_pkg::SRC_NVM, 39'h80, 3'h6, 1'b0);
        ecc(slg_pkg::SRC_NVM, 39'h180, 3'h5, 1'b1);
        ecc(slg_pkg::SRC_NVM, 39'h70_0000_0000, 3'h5, 1'b1);
        ecc(slg_pkg::SRC_RAM, 39'h80, 3'h4, 1'b1);
        ecc(slg_pkg::SRC_ROM, 39'h40_0000_0000, 3'h4, 1'b1);
        ecc(slg_pkg::SRC_ROM, 39'h0, 3'h0, 1'b0);
        wrap_up();
    end
endmodule
`default_nettype wire
